// >>> design/nco_shaper.v
/*
 * Output shaping: toggle flip-flop for fixed duty, pulse stretcher for
 * pulse frequency mode. Assumes tick and carry arrive from the accumulator
 * in the same system cycle.
 */
`timescale 1ns/1ps

module nco_shaper #(
    parameter CNT_W = 8 // wide enough for the longest pulse
) (
    input wire sys_clk_in, // system clock
    input wire sys_rst_in, // async reset, active high
    input wire enable_in, // module enable
    input wire tick_in, // input clock rising edge
    input wire carry_in, // accumulator carry this tick
    input wire pulse_mode_in, // 1 pulse, 0 fixed duty
    input wire [2:0] width_sel_in, // pulse width code
    output wire raw_out // shaped output before polarity
);
    reg toggle_q;
    reg active_q;
    reg [CNT_W-1:0] left_q;
    wire [CNT_W-1:0] width_periods;

    assign width_periods = {{(CNT_W-1){1'b0}}, 1'b1} << width_sel_in; // [R13]

    always @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            toggle_q <= 1'b0;
            active_q <= 1'b0;
            left_q <= {CNT_W{1'b0}};
        end
        else if (!enable_in)
        begin
            toggle_q <= 1'b0; // [R26]
            active_q <= 1'b0; // [R26]
            left_q <= {CNT_W{1'b0}};
        end
        else if (tick_in)
        begin
            if (carry_in && !pulse_mode_in)
                toggle_q <= ~toggle_q; // [R23] [R12]
            if (carry_in)
            begin
                // retrigger on carry; width longer than period is undefined anyway
                active_q <= 1'b1; // [R24]
                left_q <= width_periods - {{(CNT_W-1){1'b0}}, 1'b1}; // [R13]
            end
            else if (left_q != {CNT_W{1'b0}})
                left_q <= left_q - {{(CNT_W-1){1'b0}}, 1'b1};
            else
                active_q <= 1'b0; // [R24]
        end
    end

    // width only matters in pulse mode
    assign raw_out = pulse_mode_in ? active_q : toggle_q; // [R12] [R14]
endmodule // nco_shaper

// >>> design/nco_src_sel.v
/*
 * Input clock source selection for the oscillator: picks one source level
 * and reports its rising and falling edges as single-cycle ticks.
 * Assumes all source levels are synchronous to sys_clk_in.
 */
`timescale 1ns/1ps
`include "nco_defines.vh"

module nco_src_sel (
    input wire sys_clk_in, // system clock
    input wire sys_rst_in, // async reset, active high
    input wire [2:0] sel_in, // clock source code
    input wire hf_osc_in, // internal oscillator level
    input wire [3:0] lc_in, // logic cell outputs 1..4
    output wire rise_out, // rising edge tick
    output wire fall_out // falling edge tick
);
    reg lvl_q;
    reg mux_lvl;
    wire is_fosc;

    assign is_fosc = (sel_in == `NCO_CKS_FOSC);

    always @*
    begin
        mux_lvl = 1'b0;
        case (sel_in)
            `NCO_CKS_HFOSC: mux_lvl = hf_osc_in;
            `NCO_CKS_LC1: mux_lvl = lc_in[0];
            `NCO_CKS_LC2: mux_lvl = lc_in[1];
            `NCO_CKS_LC3: mux_lvl = lc_in[2];
            `NCO_CKS_LC4: mux_lvl = lc_in[3];
            default: mux_lvl = 1'b0; // reserved codes give no edges
        endcase
    end

    always @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            lvl_q <= 1'b0;
        else
            lvl_q <= mux_lvl;
    end

    // system clock source: every cycle is one input period
    assign rise_out = is_fosc | (mux_lvl & ~lvl_q); // [R16]
    assign fall_out = is_fosc | (~mux_lvl & lvl_q); // [R16]
endmodule // nco_src_sel

// >>> design/nco_top.v
/*
 * Numerically controlled oscillator: register port, 20-bit accumulator with
 * double-buffered increment, output shaping, polarity and overflow flag.
 * Assumes a plain strobe register port, read data one cycle after the read
 * strobe, and input clock sources synchronous to sys_clk_in.
 */
// The address map and the plain strobed port are this design's own decisions.
// Contract
// [R1] polarity bit inverts the final output
// [R2] polarity change with interrupts enabled sets flag
// [R3] final output drives on-chip peripherals
// [R4] every accumulator overflow sets the flag
// [R5] interrupt needs all four enable bits
// [R6] software clears the flag, hardware never
// [R7] reset clears all, increment low bit0 one
// [R8] runs regardless of sleep while source active
// [R9] request internal oscillator kept in sleep
// [R10] enable bit turns module on or off
// [R11] status bit shows current output level
// [R12] mode bit: pulse mode or fixed duty
// [R13] pulse width is two to the n
// [R14] width ignored in fixed duty mode
// [R15] software keeps pulse shorter than period
// [R16] source field selects input clock
// [R17] accumulator as three bytes, upper four bits
// [R18] accumulator updates live, no atomic read
// [R19] software must not write running accumulator
// [R20] buffer loads on next falling input edge
// [R21] software writes low increment byte last
// [R22] rising input edge adds buffer, carry overflows
// [R23] fixed duty toggles on each overflow
// [R24] pulse active after overflow for width
// [R25] disabled: increment writes load buffer at once
// [R26] disabled: hold, no overflow, output inactive
// [R27] control and flag cross domains safely
`timescale 1ns/1ps
`include "nco_defines.vh"

module nco_top #(
    parameter ACC_W = `NCO_ACC_W // accumulator width
) (
    input wire sys_clk_in, // system clock, 50 MHz
    input wire sys_rst_in, // async reset, active high
    input wire [`NCO_ADDR_W-1:0] addr_in, // register address
    input wire [`NCO_DATA_W-1:0] wr_data_in, // write data
    input wire wr_en_in, // write strobe
    input wire rd_en_in, // read strobe
    input wire hf_osc_in, // internal oscillator level
    input wire [3:0] lc_in, // logic cell outputs 1..4
    output reg [`NCO_DATA_W-1:0] rd_data_out, // read data, cycle after strobe
    output reg nco_out, // final output to peripherals
    output reg irq_out, // gated overflow interrupt
    output reg hf_osc_keep_out // keep internal oscillator in sleep
);
    // control state
    reg enable_q;
    reg invert_q;
    reg pulse_mode_q;
    reg [2:0] pws_q;
    reg [2:0] cks_q;
    reg flag_q;
    reg ie_q;
    reg periph_ie_q;
    reg global_ie_q;

    // datapath state
    reg [ACC_W-1:0] acc_q;
    reg [7:0] inc_low_q;
    reg [7:0] inc_high_q;
    reg [3:0] inc_upper_q;
    reg [ACC_W-1:0] inc_buf_q;
    reg inc_pend_q;

    wire rise_tick;
    wire fall_tick;
    wire raw_level;
    wire [ACC_W:0] acc_sum;
    wire carry;
    wire ovf_event;
    wire irq_on;
    wire [ACC_W-1:0] inc_regs;
    wire wr_ctl;
    wire wr_clk;
    wire wr_accl;
    wire wr_acch;
    wire wr_accu;
    wire wr_incl;
    wire wr_inch;
    wire wr_incu;
    wire wr_flag;
    wire wr_irqen;
    wire pol_change_irq;
    wire flag_clear;
    reg [`NCO_DATA_W-1:0] rd_mux;

    function hit;
        input [`NCO_ADDR_W-1:0] a;
        input [`NCO_ADDR_W-1:0] ofs;
        begin
            hit = (a == ofs);
        end
    endfunction

    assign wr_ctl = wr_en_in & hit(addr_in, `NCO_OFS_CONTROL);
    assign wr_clk = wr_en_in & hit(addr_in, `NCO_OFS_CLKCFG);
    assign wr_accl = wr_en_in & hit(addr_in, `NCO_OFS_ACC_LOW);
    assign wr_acch = wr_en_in & hit(addr_in, `NCO_OFS_ACC_HIGH);
    assign wr_accu = wr_en_in & hit(addr_in, `NCO_OFS_ACC_UPPER);
    assign wr_incl = wr_en_in & hit(addr_in, `NCO_OFS_INC_LOW);
    assign wr_inch = wr_en_in & hit(addr_in, `NCO_OFS_INC_HIGH);
    assign wr_incu = wr_en_in & hit(addr_in, `NCO_OFS_INC_UPPER);
    assign wr_flag = wr_en_in & hit(addr_in, `NCO_OFS_IRQ_FLAG);
    assign wr_irqen = wr_en_in & hit(addr_in, `NCO_OFS_IRQ_ENABLE);

    assign inc_regs = {inc_upper_q, inc_high_q, inc_low_q};

    // one clock domain: control bits and flag event need no synchroniser
    nco_src_sel u_src (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .sel_in(cks_q), // [R16] [R27]
        .hf_osc_in(hf_osc_in),
        .lc_in(lc_in),
        .rise_out(rise_tick),
        .fall_out(fall_tick)
    );

    assign acc_sum = {1'b0, acc_q} + {1'b0, inc_buf_q}; // [R22]
    assign carry = acc_sum[ACC_W];
    assign ovf_event = enable_q & rise_tick & carry; // [R22] [R26]

    nco_shaper #(
        .CNT_W(8)
    ) u_shape (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .enable_in(enable_q),
        .tick_in(rise_tick),
        .carry_in(carry),
        .pulse_mode_in(pulse_mode_q),
        .width_sel_in(pws_q),
        .raw_out(raw_level)
    );

    // control and configuration registers
    always @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            enable_q <= 1'b0; // [R7]
            invert_q <= 1'b0;
            pulse_mode_q <= 1'b0;
            pws_q <= 3'h0;
            cks_q <= 3'h0;
            ie_q <= 1'b0;
            periph_ie_q <= 1'b0;
            global_ie_q <= 1'b0;
        end
        else
        begin
            if (wr_ctl)
            begin
                enable_q <= wr_data_in[`NCO_CTL_EN_BIT]; // [R10]
                invert_q <= wr_data_in[`NCO_CTL_POL_BIT]; // [R1]
                pulse_mode_q <= wr_data_in[`NCO_CTL_PFM_BIT]; // [R12]
            end
            if (wr_clk)
            begin
                pws_q <= wr_data_in[`NCO_CLK_PWS_MSB:`NCO_CLK_PWS_LSB]; // [R13]
                cks_q <= wr_data_in[`NCO_CLK_CKS_MSB:`NCO_CLK_CKS_LSB]; // [R16]
            end
            if (wr_irqen)
            begin
                ie_q <= wr_data_in[`NCO_IE_BIT];
                periph_ie_q <= wr_data_in[`NCO_PERIPH_IE_BIT];
                global_ie_q <= wr_data_in[`NCO_GLOBAL_IE_BIT];
            end
        end
    end

    // accumulator: live in the input clock timing, software may overwrite bytes
    always @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            acc_q <= {ACC_W{1'b0}}; // [R7]
        else if (wr_accl | wr_acch | wr_accu)
        begin
            // writes while running win over the adder; the add of that tick is dropped
            if (wr_accl)
                acc_q[7:0] <= wr_data_in; // [R17]
            if (wr_acch)
                acc_q[15:8] <= wr_data_in; // [R17]
            if (wr_accu)
                acc_q[19:16] <= wr_data_in[3:0]; // [R17]
        end
        else if (enable_q && rise_tick)
            acc_q <= acc_sum[ACC_W-1:0]; // [R22] [R18]
    end

    // increment registers and hidden buffer
    always @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            inc_low_q <= `NCO_RST_INC_LOW; // [R7]
            inc_high_q <= `NCO_RST_INC_HIGH;
            inc_upper_q <= `NCO_RST_INC_UPPER;
            inc_buf_q <= `NCO_RST_INC; // [R7]
            inc_pend_q <= 1'b0;
        end
        else
        begin
            if (wr_incl)
                inc_low_q <= wr_data_in;
            if (wr_inch)
                inc_high_q <= wr_data_in;
            if (wr_incu)
                inc_upper_q <= wr_data_in[3:0];
            if (!enable_q)
            begin
                // disabled: buffer follows registers the cycle after a write
                inc_pend_q <= 1'b0;
                inc_buf_q <= inc_regs; // [R25]
            end
            else if (wr_incl)
                inc_pend_q <= 1'b1; // [R20] [R21]
            else if (inc_pend_q && fall_tick)
            begin
                inc_buf_q <= inc_regs; // [R20]
                inc_pend_q <= 1'b0;
            end
        end
    end

    // polarity change only counts if the polarity bit really changes
    assign irq_on = ie_q & periph_ie_q & global_ie_q;
    assign pol_change_irq = wr_ctl & irq_on & (wr_data_in[`NCO_CTL_POL_BIT] != invert_q); // [R2]
    assign flag_clear = wr_flag & ~wr_data_in[`NCO_FLAG_BIT];

    // sticky flag; a new event wins over a clear in the same cycle
    always @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            flag_q <= 1'b0; // [R7]
        else if (ovf_event | pol_change_irq)
            flag_q <= 1'b1; // [R4] [R2]
        else if (flag_clear)
            flag_q <= 1'b0; // [R6]
    end

    // outputs all registered
    always @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            nco_out <= 1'b0;
            irq_out <= 1'b0;
            hf_osc_keep_out <= 1'b0;
        end
        else
        begin
            nco_out <= raw_level ^ invert_q; // [R1] [R3] [R26]
            irq_out <= flag_q & enable_q & irq_on; // [R5]
            // no sleep gating anywhere: block keeps running [R8]
            hf_osc_keep_out <= enable_q & (cks_q == `NCO_CKS_HFOSC); // [R9]
        end
    end

    always @*
    begin
        rd_mux = 8'h00;
        if (hit(addr_in, `NCO_OFS_CONTROL))
            rd_mux = {enable_q, 1'b0, nco_out, invert_q, 3'h0, pulse_mode_q}; // [R11]
        else if (hit(addr_in, `NCO_OFS_CLKCFG))
            rd_mux = {pws_q, 2'h0, cks_q};
        else if (hit(addr_in, `NCO_OFS_ACC_LOW))
            rd_mux = acc_q[7:0]; // [R17]
        else if (hit(addr_in, `NCO_OFS_ACC_HIGH))
            rd_mux = acc_q[15:8];
        else if (hit(addr_in, `NCO_OFS_ACC_UPPER))
            rd_mux = {4'h0, acc_q[19:16]}; // [R17]
        else if (hit(addr_in, `NCO_OFS_INC_LOW))
            rd_mux = inc_low_q;
        else if (hit(addr_in, `NCO_OFS_INC_HIGH))
            rd_mux = inc_high_q;
        else if (hit(addr_in, `NCO_OFS_INC_UPPER))
            rd_mux = {4'h0, inc_upper_q};
        else if (hit(addr_in, `NCO_OFS_IRQ_FLAG))
            rd_mux = {7'h00, flag_q};
        else if (hit(addr_in, `NCO_OFS_IRQ_ENABLE))
            rd_mux = {5'h00, global_ie_q, periph_ie_q, ie_q};
        else
            rd_mux = 8'h00;
    end

    // read data stands only in the cycle after the strobe
    always @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            rd_data_out <= 8'h00;
        else if (rd_en_in)
            rd_data_out <= rd_mux;
        else
            rd_data_out <= 8'h00;
    end
endmodule // nco_top

// >>> inc/nco_defines.vh
/*
 * Register map, field positions, reset values and source codes for the
 * numerically controlled oscillator. Assumes an 8-bit register port.
 */
`ifndef NCO_DEFINES_VH
`define NCO_DEFINES_VH

`define NCO_ADDR_W 4
`define NCO_DATA_W 8
`define NCO_ACC_W 20

`define NCO_OFS_CONTROL 4'h0
`define NCO_OFS_CLKCFG 4'h1
`define NCO_OFS_ACC_LOW 4'h2
`define NCO_OFS_ACC_HIGH 4'h3
`define NCO_OFS_ACC_UPPER 4'h4
`define NCO_OFS_INC_LOW 4'h5
`define NCO_OFS_INC_HIGH 4'h6
`define NCO_OFS_INC_UPPER 4'h7
`define NCO_OFS_IRQ_FLAG 4'h8
`define NCO_OFS_IRQ_ENABLE 4'h9

`define NCO_CTL_EN_BIT 7
`define NCO_CTL_OUT_BIT 5
`define NCO_CTL_POL_BIT 4
`define NCO_CTL_PFM_BIT 0
`define NCO_CLK_PWS_MSB 7
`define NCO_CLK_PWS_LSB 5
`define NCO_CLK_CKS_MSB 2
`define NCO_CLK_CKS_LSB 0
`define NCO_FLAG_BIT 0
`define NCO_IE_BIT 0
`define NCO_PERIPH_IE_BIT 1
`define NCO_GLOBAL_IE_BIT 2

`define NCO_CTL_WMASK 8'h91
`define NCO_CLK_WMASK 8'he7
`define NCO_IRQEN_WMASK 8'h07

`define NCO_RST_CONTROL 8'h00
`define NCO_RST_CLKCFG 8'h00
`define NCO_RST_INC_LOW 8'h01
`define NCO_RST_INC_HIGH 8'h00
`define NCO_RST_INC_UPPER 4'h0
`define NCO_RST_INC 20'h00001

`define NCO_CKS_FOSC 3'h0
`define NCO_CKS_HFOSC 3'h1
`define NCO_CKS_LC1 3'h2
`define NCO_CKS_LC2 3'h3
`define NCO_CKS_LC3 3'h4
`define NCO_CKS_LC4 3'h5

`endif

// >>> verification/nco_src_model.sv
/* far side model: source levels for the oscillator and a consumer
   that counts output rises. assumes the bench system clock. */
`timescale 1ns/1ps
module nco_src_model (
    input wire sys_clk_in, // system clock
    input wire sys_rst_in, // reset
    input wire run_in, // sources move only while set
    input wire nco_in, // oscillator output
    output reg hf_osc_out, // internal oscillator level
    output reg [3:0] lc_out, // logic cell levels
    output reg [15:0] rise_cnt_out // output rises seen
);
    reg [3:0] div_q;
    reg nco_q;
    always @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            div_q <= 4'h0;
            hf_osc_out <= 1'b0;
            lc_out <= 4'h0;
            nco_q <= 1'b0;
            rise_cnt_out <= 16'h0;
        end
        else
        begin
            div_q <= div_q + 4'h1;
            hf_osc_out <= run_in & div_q[1];
            // stopped sources sit low rather than freeze mid-level
            lc_out <= run_in ? div_q : 4'h0;
            nco_q <= nco_in;
            rise_cnt_out <= rise_cnt_out + {15'h0, nco_in & ~nco_q};
        end
    end
endmodule // nco_src_model

// >>> verification/nco_top_asserts.sv
/* port checker for nco_top.
   assumes one clock domain and a bind onto every nco_top. */
`timescale 1ns/1ps
module nco_top_asserts #(
    parameter ACC_W = 20 // accumulator width
) (
    input wire sys_clk_in, // clock
    input wire sys_rst_in, // reset
    input wire [3:0] addr_in, // address
    input wire [7:0] wr_data_in, // write data
    input wire wr_en_in, // write strobe
    input wire rd_en_in, // read strobe
    input wire hf_osc_in, // oscillator level
    input wire [3:0] lc_in, // cell levels
    input wire [7:0] rd_data_out, // read data
    input wire nco_out, // output
    input wire irq_out, // interrupt
    input wire hf_osc_keep_out // keep request
);
    reg en_q;
    reg pol_q;
    reg [2:0] cks_q;
    reg [2:0] ie_q;
    wire gate_w = en_q && (&ie_q);
    wire keep_w = en_q && (cks_q == 3'h1);
    // shadow of the software view, updated on the same edge as the design
    always @(posedge sys_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            en_q <= 1'b0;
            pol_q <= 1'b0;
            cks_q <= 3'h0;
            ie_q <= 3'h0;
        end
        else if (wr_en_in && addr_in == 4'h0)
        begin
            en_q <= wr_data_in[7];
            pol_q <= wr_data_in[4];
        end
        else if (wr_en_in && addr_in == 4'h1)
            cks_q <= wr_data_in[2:0];
        else if (wr_en_in && addr_in == 4'h9)
            ie_q <= wr_data_in[2:0];
    end
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    sequence held_off;
        (!en_q && $stable(pol_q)) [*3];
    endsequence
    // reserved sources never tick, so the output must freeze
    sequence no_ticks;
        (en_q && cks_q[2:1] == 2'b11 && !wr_en_in) [*4];
    endsequence
    chk_reset_clear: assert property ($fell(sys_rst_in) |-> !nco_out && !irq_out && !hf_osc_keep_out)
        else $error("outputs not clear after reset");
    chk_keep_osc: assert property ($stable(keep_w) |-> hf_osc_keep_out == keep_w)
        else $error("oscillator keep request wrong");
    chk_off_level: assert property (held_off |-> nco_out == pol_q)
        else $error("disabled output not at inactive level");
    chk_irq_gate: assert property (irq_out |-> $past(gate_w))
        else $error("interrupt without all enables");
    chk_flag_sticky: assert property (irq_out && !wr_en_in && !$past(wr_en_in) |=> irq_out)
        else $error("interrupt dropped without software");
    chk_ctrl_read: assert property (rd_en_in && addr_in == 4'h0 |=> rd_data_out[7] == en_q
        && rd_data_out[4] == pol_q && !rd_data_out[6] && rd_data_out[3:1] == 3'h0)
        else $error("control readback wrong");
    chk_upper_zero: assert property (rd_en_in && (addr_in == 4'h4 || addr_in == 4'h7)
        |=> rd_data_out[7:4] == 4'h0)
        else $error("upper byte high nibble not zero");
    chk_reserved_src: assert property (no_ticks |=> $stable(nco_out))
        else $error("output moved on reserved source");
endmodule // nco_top_asserts

bind nco_top nco_top_asserts #(.ACC_W(ACC_W)) u_nco_chk (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
    .hf_osc_in(hf_osc_in), .lc_in(lc_in), .rd_data_out(rd_data_out), .nco_out(nco_out),
    .irq_out(irq_out), .hf_osc_keep_out(hf_osc_keep_out));

// >>> verification/tb_top.sv
/* self-checking bench for nco_top.
   assumes nco_src_model on the far side and the bound checker. */
`timescale 1ns/1ps
module tb_top;
    logic sys_clk_in = 1'b0;
    logic rst_q = 1'b1;
    logic [3:0] addr_q = 4'h0;
    logic [7:0] wdata_q = 8'h00;
    logic wr_q = 1'b0;
    logic rd_q = 1'b0;
    logic run_q = 1'b0;
    wire hf_w;
    wire [3:0] lc_w;
    wire [15:0] rise_w;
    wire [7:0] rd_data_out;
    wire nco_out;
    wire irq_out;
    wire hf_osc_keep_out;
    int num_errors = 0;
    int compares = 0;
    int cyc = 0;
    nco_top dut (.sys_clk_in(sys_clk_in), .sys_rst_in(rst_q), .addr_in(addr_q), .wr_data_in(wdata_q),
        .wr_en_in(wr_q), .rd_en_in(rd_q), .hf_osc_in(hf_w), .lc_in(lc_w), .rd_data_out(rd_data_out),
        .nco_out(nco_out), .irq_out(irq_out), .hf_osc_keep_out(hf_osc_keep_out));
    nco_src_model src (.sys_clk_in(sys_clk_in), .sys_rst_in(rst_q), .run_in(run_q), .nco_in(nco_out),
        .hf_osc_out(hf_w), .lc_out(lc_w), .rise_cnt_out(rise_w));
    initial
    begin
        forever #10 sys_clk_in = ~sys_clk_in;
    end
    task automatic print_verdict;
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge sys_clk_in)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            $display("[ERR] %0t run too long", $time);
            print_verdict();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        addr_q <= a;
        wdata_q <= d;
        wr_q <= 1'b1;
        @(posedge sys_clk_in);
        wr_q <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
        @(posedge sys_clk_in);
        addr_q <= a;
        rd_q <= 1'b1;
        @(posedge sys_clk_in);
        rd_q <= 1'b0;
        #1;
        chk({8'h00, rd_data_out}, {8'h00, e});
    endtask
    task automatic t_regs;
        logic [19:0] tbl [7] = '{20'h06e00, 20'h1ffe7, 20'h25a5a, 20'h3a5a5, 20'h4ff0f, 20'h7ff0f, 20'haff00};
        for (int a = 0; a < 11; a++)
            rdchk(a[3:0], (a == 5) ? 8'h01 : 8'h00);
        foreach (tbl[i])
        begin
            wr(tbl[i][19:16], tbl[i][15:8]);
            rdchk(tbl[i][19:16], tbl[i][7:0]);
        end
        wr(4'h1, 8'h00);
        wr(4'h7, 8'h00);
        $display("t_regs done");
    endtask
    task automatic t_fixed_duty;
        int n0;
        wr(4'h9, 8'h07);
        wr(4'h1, 8'he0);
        wr(4'h7, 8'h08);
        wr(4'h6, 8'h00);
        wr(4'h5, 8'h00);
        wr(4'h0, 8'h80);
        tick(8);
        n0 = rise_w;
        tick(40);
        chk(rise_w - n0[15:0], 16'd10);
        chk(irq_out, 1'b1);
        rdchk(4'h8, 8'h01);
        // running: upper byte alone must not reach the buffer
        wr(4'h7, 8'h04);
        tick(8);
        n0 = rise_w;
        tick(40);
        chk(rise_w - n0[15:0], 16'd10);
        wr(4'h5, 8'h00);
        tick(8);
        n0 = rise_w;
        tick(40);
        chk(rise_w - n0[15:0], 16'd5);
        wr(4'h0, 8'h00);
        wr(4'h8, 8'h00);
        tick(3);
        rdchk(4'h8, 8'h00);
        chk(irq_out | nco_out, 1'b0);
        $display("t_fixed_duty done");
    endtask
    task automatic t_pol;
        wr(4'h0, 8'h10);
        tick(4);
        chk(nco_out, 1'b1);
        rdchk(4'h0, 8'h30);
        rdchk(4'h8, 8'h01);
        wr(4'h0, 8'h00);
        tick(4);
        wr(4'h8, 8'h00);
        $display("t_pol done");
    endtask
    task automatic t_pulse;
        int i;
        int w;
        for (int n = 0; n < 8; n++)
        begin
            wr(4'h0, 8'h00);
            wr(4'h2, 8'h00);
            wr(4'h3, 8'h00);
            wr(4'h4, 8'h00);
            wr(4'h1, {n[2:0], 5'h00});
            wr(4'h7, 8'h00);
            wr(4'h6, 8'h10);
            wr(4'h5, 8'h00);
            wr(4'h0, 8'h81);
            i = 0;
            w = 0;
            tick(1);
            while (nco_out !== 1'b1 && i < 600)
            begin
                tick(1);
                i++;
            end
            while (nco_out === 1'b1 && w < 300)
            begin
                tick(1);
                w++;
            end
            chk(w[15:0], 16'd1 << n);
        end
        $display("t_pulse done");
    endtask
    task automatic t_src;
        int n0;
        wr(4'h0, 8'h00);
        run_q <= 1'b1;
        wr(4'h7, 8'h08);
        wr(4'h6, 8'h00);
        wr(4'h5, 8'h00);
        for (int c = 0; c < 8; c++)
        begin
            wr(4'h0, 8'h00);
            wr(4'h1, {5'h00, c[2:0]});
            wr(4'h0, 8'h80);
            tick(8);
            n0 = rise_w;
            chk(hf_osc_keep_out, c == 1);
            tick(200);
            chk(rise_w != n0[15:0], c < 6);
        end
        wr(4'h0, 8'h00);
        run_q <= 1'b0;
        $display("t_src done");
    endtask
    initial
    begin
        repeat (4) @(posedge sys_clk_in);
        rst_q <= 1'b0;
        t_regs();
        t_fixed_duty();
        t_pol();
        t_pulse();
        t_src();
        print_verdict();
    end
endmodule // tb_top
